// ---- outm_timing_map.vh ----
// constants for the output update timing engine
`ifndef OUTM_TIMING_MAP_VH
`define OUTM_TIMING_MAP_VH
`define OUTM_DIV_W      16
`define OUTM_DIV_ONE    16'h0001
`define OUTM_LINES      8
`define OUTM_SEL_W      3
`define OUTM_MODE_DIV   1'b0
`define OUTM_MODE_EXT   1'b1
`define OUTM_ST_IDLE    2'h0
`define OUTM_ST_ARMED   2'h1
`define OUTM_ST_RUN     2'h2
`define OUTM_PULSE_LEN  2'h2
`define OUTM_LOW_IDLE   2'h0
`define OUTM_LOW_LAST   2'h1
`endif

// ---- outm_sync2.v ----
// two-stage synchroniser for a single level
`timescale 1ns/100ps
`default_nettype none
module outm_sync2 (
   input  wire clk,
   input  wire rst,
   input  wire asyncIn,
   output reg  syncOut
);
   reg stage1;
   always @(posedge clk) begin
      if (rst) begin
         stage1  <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule // outm_sync2
`default_nettype wire

// ---- outm_update_engine.v ----
// output update timing engine: update clock, start and pause handling, exports
// Operation
// - external clock mode: timebase and sync timebase come from the external clock
// - divided mode: every update is timed by interval counter terminal pulses
// - divided mode: sync timebase is the inverse of the update timebase
// - rising-edge mode: external inputs sampled on falling timebase edge
// - selected start trigger is exported without any register stage
// - asserted pause suspends a running generation; no updates while paused
// - selected pause is captured on the sync timebase rising edge
// - trigger sampled by a flop on the clock; source meets setup and hold
// - exportable signals are start trigger, pause trigger and update clock only
// - pause trigger exported asynchronously, only to chassis trigger bus lines
// - exported update clock falling edge launched from the update timebase
// - exported update clock active low, one falling edge per conversion
// - interval counter emits one update every N timebase periods
// - converter performs one conversion on every update clock pulse
// - with pause enabled, generate only while the pause gate is enabled
// - start comes from software command or external pulse, then output begins
`timescale 1ns/100ps
`default_nettype none
`include "outm_timing_map.vh"
module outm_update_engine (
   input  wire                     ref_clk,
   input  wire                     sys_rst,
   input  wire                     clockMode,
   input  wire [`OUTM_DIV_W-1:0]   divideN,
   input  wire                     pauseEnable,
   input  wire                     pauseActiveLow,
   input  wire                     swStart,
   input  wire                     stopCmd,
   input  wire [`OUTM_SEL_W-1:0]   startSel,
   input  wire [`OUTM_SEL_W-1:0]   pauseSel,
   input  wire [`OUTM_LINES-1:0]   programmable_function_line_in,
   input  wire [`OUTM_LINES-1:0]   chassis_trigger_bus_line_in,
   input  wire                     extTimebase,
   input  wire                     extUpdateClk,
   output wire                     startTrigOut,
   output wire                     pauseTrigBusOut,
   output reg                      updateClkOut_n,
   output reg                      convertStrobe,
   output reg                      running,
   output reg                      paused
);
   // start export stays purely combinational: no resync stage allowed
   wire selStartRaw = chassis_trigger_bus_line_in[startSel];
   wire selPauseRaw = chassis_trigger_bus_line_in[pauseSel];
   assign startTrigOut    = selStartRaw;
   assign pauseTrigBusOut = selPauseRaw;

   // every external line crosses into ref_clk for the control logic; only the start and pause exports use the raw bus lines
   wire [`OUTM_LINES-1:0] pfiSync;
   wire [`OUTM_LINES-1:0] busSync;
   wire                   tbSync;
   wire                   extClkSync;
   genvar gi;
   generate
      for (gi = 0; gi < `OUTM_LINES; gi = gi + 1) begin : g_sync
         outm_sync2 u_pfi (
            .clk     (ref_clk),
            .rst     (sys_rst),
            .asyncIn (programmable_function_line_in[gi]),
            .syncOut (pfiSync[gi])
         );
         outm_sync2 u_bus (
            .clk     (ref_clk),
            .rst     (sys_rst),
            .asyncIn (chassis_trigger_bus_line_in[gi]),
            .syncOut (busSync[gi])
         );
      end
   endgenerate
   outm_sync2 u_tb (
      .clk     (ref_clk),
      .rst     (sys_rst),
      .asyncIn (extTimebase),
      .syncOut (tbSync)
   );
   outm_sync2 u_ext (
      .clk     (ref_clk),
      .rst     (sys_rst),
      .asyncIn (extUpdateClk),
      .syncOut (extClkSync)
   );

   // timebase source picked by the mode latched while idle; a mode change
   // during a run would otherwise splice two timebases into one period
   reg  runMode;
   wire tbSrc = (runMode == `OUTM_MODE_EXT) ? extClkSync : tbSync;
   reg  tbPrev;
   always @(posedge ref_clk) begin
      if (sys_rst)
         tbPrev <= 1'b0;
      else
         tbPrev <= tbSrc;
   end
   wire tbRise   = tbSrc & ~tbPrev;
   // sync timebase is the inverse, so its rising edge is the timebase fall
   wire syncTbRise = ~tbSrc & tbPrev;

   // trigger sampling on sync timebase rising edge
   reg startPrev;
   reg pauseLvl;
   wire startLine = busSync[startSel] | pfiSync[startSel];
   wire pauseLine = (busSync[pauseSel] | pfiSync[pauseSel]) ^ pauseActiveLow;
   // start edge is judged only at the sync timebase rise
   always @(posedge ref_clk) begin
      if (sys_rst)
         startPrev <= 1'b0;
      else if (syncTbRise)
         startPrev <= startLine;
   end
   // pause level only moves on the sync timebase edge, like the gate itself
   always @(posedge ref_clk) begin
      if (sys_rst)
         pauseLvl <= 1'b0;
      else if (syncTbRise)
         pauseLvl <= pauseEnable & pauseLine;
   end
   wire extStartEdge = syncTbRise & startLine & ~startPrev;

   // run control
   localparam ST_IDLE = `OUTM_ST_IDLE;
   localparam ST_RUN  = `OUTM_ST_RUN;
   reg [1:0] state;
   reg [1:0] next_state;
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (swStart || extStartEdge)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (stopCmd)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always @(posedge ref_clk) begin
      if (sys_rst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // interval counter, frozen while paused and held before start
   reg  [`OUTM_DIV_W-1:0] count;
   reg  [`OUTM_DIV_W-1:0] next_count;
   reg                    updPulse;
   reg                    next_updPulse;
   wire                   isRun   = (state == ST_RUN);
   wire                   advance = isRun & ~pauseLvl & tbRise;
   // divideN of zero lands on the terminal count at once and acts as one
   wire                   termCnt = (count <= `OUTM_DIV_ONE);
   wire                   extTick = isRun & ~pauseLvl & tbRise;

   // mode follows its input only while idle
   always @(posedge ref_clk) begin
      if (sys_rst)
         runMode <= `OUTM_MODE_DIV;
      else if (!isRun)
         runMode <= clockMode;
   end

   always @* begin
      next_count    = count;
      next_updPulse = 1'b0;
      if (!isRun) begin
         next_count = divideN;
      end else if (runMode == `OUTM_MODE_EXT) begin
         next_updPulse = extTick;
      end else if (advance) begin
         if (termCnt) begin
            next_count    = divideN;
            next_updPulse = 1'b1;
         end else begin
            next_count = count - `OUTM_DIV_ONE;
         end
      end
   end
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         count    <= divideN;
         updPulse <= 1'b0;
      end else begin
         count    <= next_count;
         updPulse <= next_updPulse;
      end
   end

   // status flags trail the controller by one clock
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         convertStrobe <= 1'b0;
         running       <= 1'b0;
         paused        <= 1'b0;
      end else begin
         convertStrobe <= updPulse;
         running       <= isRun;
         paused        <= isRun & pauseLvl;
      end
   end

   // exported update clock: low for a short window per conversion;
   // a stop in mid-pulse still lets the window run out
   reg [1:0] lowCnt;
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         updateClkOut_n <= 1'b1;
         lowCnt         <= `OUTM_LOW_IDLE;
      end else if (updPulse) begin
         updateClkOut_n <= 1'b0;
         lowCnt         <= `OUTM_PULSE_LEN;
      end else if (lowCnt != `OUTM_LOW_IDLE) begin
         lowCnt <= lowCnt - `OUTM_LOW_LAST;
         if (lowCnt == `OUTM_LOW_LAST)
            updateClkOut_n <= 1'b1;
      end
   end
endmodule // outm_update_engine
`default_nettype wire

// ---- outm_update_engine_assertions.sv ----
// concurrent checks on the update engine ports
`timescale 1ns/100ps
`default_nettype none
`include "outm_timing_map.vh"
module outm_engine_chk (
   input wire logic                   ref_clk,
   input wire logic                   sys_rst,
   input wire logic [`OUTM_SEL_W-1:0] startSel,
   input wire logic [`OUTM_SEL_W-1:0] pauseSel,
   input wire logic [`OUTM_LINES-1:0] chassis_trigger_bus_line_in,
   input wire logic                   startTrigOut,
   input wire logic                   pauseTrigBusOut,
   input wire logic                   updateClkOut_n,
   input wire logic                   convertStrobe,
   input wire logic                   running,
   input wire logic                   paused
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence lowPulse; !updateClkOut_n[*2] ##1 updateClkOut_n; endsequence
   start_export_a: assert property (startTrigOut == chassis_trigger_bus_line_in[startSel])
      else $error("start export mismatch");
   pause_export_a: assert property (pauseTrigBusOut == chassis_trigger_bus_line_in[pauseSel])
      else $error("pause export mismatch");
   strobe_on_fall_a: assert property (convertStrobe |-> $fell(updateClkOut_n))
      else $error("strobe without clock fall");
   pulse_shape_a: assert property ($fell(updateClkOut_n) |-> lowPulse)
      else $error("update pulse width wrong");
   strobe_gap_a: assert property (convertStrobe |=> !convertStrobe[*2])
      else $error("updates too close");
   idle_quiet_a: assert property (!running && !$past(running) |-> !convertStrobe)
      else $error("update while idle");
   pause_quiet_a: assert property (paused && $past(paused) |-> !convertStrobe)
      else $error("update while paused");
   reset_state_a: assert property ($past(sys_rst) |-> updateClkOut_n && !running)
      else $error("bad state after reset");
endmodule // outm_engine_chk
bind outm_update_engine outm_engine_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .startSel(startSel), .pauseSel(pauseSel),
   .chassis_trigger_bus_line_in(chassis_trigger_bus_line_in),
   .startTrigOut(startTrigOut), .pauseTrigBusOut(pauseTrigBusOut),
   .updateClkOut_n(updateClkOut_n), .convertStrobe(convertStrobe),
   .running(running), .paused(paused));
`default_nettype wire

// ---- outm_line_source.sv ----
// far-side source of the timebase and external update clock
`timescale 1ns/100ps
`default_nettype none
module outm_line_source (
   input  wire logic ref_clk,
   output wire logic extTimebase,
   output wire logic extUpdateClk
);
   logic [3:0] phase = 4'h0;
   // free-running; moves on the falling edge so setup and hold stay wide
   always @(negedge ref_clk) begin
      phase <= phase + 4'h1;
   end
   assign extTimebase  = phase[2];
   assign extUpdateClk = phase[3] & phase[2];
endmodule // outm_line_source
`default_nettype wire

// ---- outm_update_engine_tb.sv ----
// self-checking bench for the update engine
`timescale 1ns/100ps
`default_nettype none
module outm_update_engine_tb;
   logic ref_clk = 1'b0, sys_rst = 1'b1, clockMode = 1'b0, swStart = 1'b0, stopCmd = 1'b0;
   logic pauseEnable = 1'b0, pauseActiveLow = 1'b0;
   logic [15:0] divideN = 16'h0004;
   logic [2:0] startSel = 3'h0, pauseSel = 3'h1;
   logic [7:0] pfl = 8'h00, bus = 8'h00;
   wire logic tb, uc, stOut, psOut, upd_n, strobe, running, paused;
   int failures = 0, n_compared = 0, cyc = 0, n;
   outm_line_source u_outm_line_source (.ref_clk(ref_clk), .extTimebase(tb), .extUpdateClk(uc));
   outm_update_engine u_outm_update_engine (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .clockMode(clockMode), .divideN(divideN), .pauseEnable(pauseEnable),
      .pauseActiveLow(pauseActiveLow), .swStart(swStart), .stopCmd(stopCmd),
      .startSel(startSel), .pauseSel(pauseSel), .programmable_function_line_in(pfl),
      .chassis_trigger_bus_line_in(bus), .extTimebase(tb), .extUpdateClk(uc),
      .startTrigOut(stOut), .pauseTrigBusOut(psOut), .updateClkOut_n(upd_n),
      .convertStrobe(strobe), .running(running), .paused(paused));
   initial forever #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (++cyc == 5000) begin
      failures++;
      complete_run;
   end
   task automatic chk(input logic [15:0] exp, input logic [15:0] act);
      n_compared++;
      if (act !== exp) begin
         failures++;
         $display("ERROR %0t exp %h got %h", $time, exp, act);
      end
   endtask
   // cycles to the next update, capped at 300
   task automatic gap(output int k);
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (strobe !== 1'b1 && k < 300);
   endtask
   // second reset while still idle; lines sweep under it so no edge starts the engine
   task automatic t_export;
      @(negedge ref_clk);
      sys_rst = 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         startSel = i[2:0];
         pauseSel = 3'h7 - i[2:0];
         bus = 8'h01 << i;
         pfl = ~bus;
         #1;
         chk(16'h0001, stOut);
         chk(16'h0000, psOut);
      end
      chk(16'h0001, upd_n);
      chk(16'h0000, running);
      startSel = 3'h0;
      pauseSel = 3'h1;
      bus = 8'h00;
      pfl = 8'h00;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      $display("export test done");
   endtask
   task automatic t_divided;
      repeat (3) @(negedge ref_clk);
      swStart = 1'b1;
      @(negedge ref_clk);
      swStart = 1'b0;
      chk(16'h0000, running);
      @(negedge ref_clk);
      chk(16'h0000, strobe);
      @(negedge ref_clk);
      chk(16'h0001, running);
      gap(n);
      gap(n);
      chk(16'h0020, n[15:0]);
      gap(n);
      chk(16'h0020, n[15:0]);
      chk(16'h0000, upd_n);
      $display("divided test done");
   endtask
   // pause lands with the interval counter half way, so a clear would show
   task automatic t_pause;
      repeat (16) @(negedge ref_clk);
      pauseEnable = 1'b1;
      bus[1] = 1'b1;
      repeat (12) @(negedge ref_clk);
      chk(16'h0001, paused);
      gap(n);
      chk(16'h012c, n[15:0]);
      chk(16'h0001, upd_n);
      bus[1] = 1'b0;
      gap(n);
      chk(16'h0010, n[15:0]);
      gap(n);
      chk(16'h0020, n[15:0]);
      stopCmd = 1'b1;
      @(negedge ref_clk);
      stopCmd = 1'b0;
      pauseEnable = 1'b0;
      clockMode = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(16'h0000, running);
      $display("pause test done");
   endtask
   task automatic t_ext;
      bus[0] = 1'b1;
      repeat (24) @(negedge ref_clk);
      chk(16'h0001, running);
      gap(n);
      gap(n);
      chk(16'h0010, n[15:0]);
      gap(n);
      chk(16'h0010, n[15:0]);
      pauseActiveLow = 1'b1;
      pauseEnable = 1'b1;
      repeat (24) @(negedge ref_clk);
      chk(16'h0001, paused);
      bus[1] = 1'b1;
      repeat (24) @(negedge ref_clk);
      chk(16'h0000, paused);
      $display("external clock test done");
   endtask
   task automatic complete_run;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_export;
      t_divided;
      t_pause;
      t_ext;
      complete_run;
   end
endmodule // outm_update_engine_tb
`default_nettype wire
